// file: bench/debug_tool.sv
`timescale 1ns/1ps
`default_nettype none
module debug_tool (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic go,
  input  wire logic probe_ready_n,
  output logic      probe_request_n
);
  always @(negedge clk) begin
    if (rst || !probe_ready_n) begin
      probe_request_n <= 1'b1;
    end else if (go) begin
      probe_request_n <= 1'b0;
    end
  end
endmodule : debug_tool
`default_nettype wire

// file: bench/sideband_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sideband_properties (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic [1:0]             local_irq_pins,
  input wire sideband_pkg::irq_out_t irq_out,
  input wire logic                   lock_seq_start,
  input wire logic                   lock_seq_last_done,
  input wire logic                   bus_lock_n,
  input wire logic                   bus_owner,
  input wire logic                   temp_max_detect,
  input wire logic                   overtemp_n,
  input wire logic                   probe_request_n,
  input wire logic                   probe_ready_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // a start only counts from a settled idle, not the finish cycle
  sequence lock_open_s;
    lock_seq_start && bus_lock_n && $past(bus_lock_n);
  endsequence
  role_excl_a: assert property (
    !(irq_out.lapic_irq0 && irq_out.maskable_irq_req)) else $error("roles");
  sync_delay_a: assert property (
    irq_out.lapic_irq0 || irq_out.maskable_irq_req
    |-> $past(local_irq_pins[0], 3)) else $error("sync");
  lock_take_a: assert property (
    lock_open_s |=> !bus_lock_n) else $error("lock start");
  lock_hold_a: assert property (
    !bus_lock_n && !lock_seq_last_done |=> !bus_lock_n) else $error("hold");
  lock_end_a: assert property (
    !bus_lock_n && lock_seq_last_done |=> bus_lock_n) else $error("end");
  owner_kept_a: assert property (
    !bus_lock_n |-> bus_owner) else $error("owner");
  hot_flag_a: assert property (
    1'b1 |=> overtemp_n != $past(temp_max_detect)) else $error("hot");
  probe_ack_a: assert property (
    $fell(probe_ready_n) |-> !$past(probe_request_n, 5)) else $error("probe");
endmodule : sideband_properties
bind cpu_sideband_lock_irq_logic sideband_properties chk (.*);
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst, dis, st, dn, pr, tm, te, dr, go, rq, lk, own, hot, tca, rdy;
  logic [1:0]             pins, p;
  logic [1:0]             ph[$] = '{2'h0, 2'h0};
  logic [31:0]            r;
  sideband_pkg::irq_out_t irq;
  int                     failures, n_tests, ls, cyc, mq, mc, mp;
  function automatic logic [31:0] nx(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nx
  task automatic chk(logic [3:0] g, logic [3:0] e);
    n_tests++;
    if (g !== e) failures++;
    if (g !== e) $display("unexpected %0t %h %h", $time, g, e);
  endtask : chk
  task automatic finish_test;
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  initial forever #12.5 clk = ~clk;
  cpu_sideband_lock_irq_logic DUT (.clk(clk), .rst(rst),
    .local_irq_pins(pins), .local_ctrl_disable(dis), .irq_out(irq),
    .lock_seq_start(st), .lock_seq_last_done(dn), .priority_bus_req_n(pr),
    .bus_lock_n(lk), .bus_owner(own), .temp_max_detect(tm),
    .thermal_ctrl_en(te), .overtemp_n(hot), .thermal_ctrl_active(tca),
    .probe_request_n(rq), .debug_ready(dr), .probe_ready_n(rdy));
  debug_tool tool (.clk(clk), .rst(rst), .go(go), .probe_ready_n(rdy),
    .probe_request_n(rq));
  // inputs seen here are those the last rising edge took
  always @(negedge clk) begin
    ph.push_front(rst ? 2'h0 : pins);
    p = ph[2];
    if (ph.size() > 3) void'(ph.pop_back());
    if (rst) ls = 0;
    else if (ls == 1) ls = dn ? 2 : 1;
    else ls = (ls == 0 && st) ? 1 : 0;
    if (cyc[8:0] > 5) chk(irq, {p[0], p[1], 2'h0} >> (dis ? 2 : 0));
    chk({3'h0, lk}, {3'h0, ls != 1});
    chk({3'h0, own}, {3'h0, rst | pr | ls == 1});
    chk({2'h0, hot, tca}, {2'h0, rst | !tm, !rst & tm & te});
    if (rst) begin
      mq = 0;
      mc = 0;
      mp = 0;
    end else begin
      if (mq == 0) begin
        mc = 0;
        mp = 0;
      end else if (mc != sideband_pkg::probe_ack_cycles) begin
        mc++;
      end else begin
        mp = dr;
      end
      mq = !rq;
    end
    chk({3'h0, rdy}, {3'h0, mp == 0});
    r = nx(r);
    cyc++;
    pins = r[1:0];
    st = &r[4:2];
    dn = &r[6:5];
    pr = |r[8:7];
    tm = &r[10:9];
    te = r[11];
    dr = |r[13:12];
    go = r[14];
    dis = cyc[9];
  end
  initial begin
    r = 32'h0000_dbd0;
    rst = 1'b1;
    {pins, st, dn, pr, tm, te, dr, go, dis} = '0;
    repeat (12) @(posedge clk);
    @(negedge clk) rst <= 1'b0;
    repeat (1200) @(posedge clk);
    finish_test();
  end
  initial begin
    #(1400 * 25);
    failures++;
    finish_test();
  end
endmodule : tb
`default_nettype wire

// file: hdl/cpu_sideband_lock_irq_logic.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_sideband_lock_irq_logic (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [1:0]            local_irq_pins,
  input  wire logic                  local_ctrl_disable,
  output sideband_pkg::irq_out_t     irq_out,
  input  wire logic                  lock_seq_start,
  input  wire logic                  lock_seq_last_done,
  input  wire logic                  priority_bus_req_n,
  output logic                       bus_lock_n,
  output logic                       bus_owner,
  input  wire logic                  temp_max_detect,
  input  wire logic                  thermal_ctrl_en,
  output logic                       overtemp_n,
  output logic                       thermal_ctrl_active,
  input  wire logic                  probe_request_n,
  input  wire logic                  debug_ready,
  output logic                       probe_ready_n
);
  logic [1:0]              irq_sync;
  logic                    ctrl_en_ff;
  sideband_pkg::irq_out_t  irq_ff;
  sideband_pkg::lock_state_t lock_ff;
  sideband_pkg::lock_state_t nxt_lock;
  logic                    lock_ff_out;
  logic                    owner_ff;
  logic                    hot_ff;
  logic                    tca_ff;
  logic                    probe_request_n_ff;
  logic [3:0]              probe_cnt_ff;
  logic                    probe_ready_n_ff;

  // [R2] async pins synchronised
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      sync2 u_sync (
        .clk (clk),
        .rst (rst),
        .d   (local_irq_pins[gi]),
        .q   (irq_sync[gi])
      );
    end
  endgenerate

  // [R3] enabled after reset
  always_ff @(posedge clk) begin
    if (rst) ctrl_en_ff <= sideband_pkg::ctrl_en_reset;
    else     ctrl_en_ff <= ~local_ctrl_disable;
  end

  // [R1] route by controller mode
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_ff <= '0;
    end else begin
      irq_ff.lapic_irq0       <= ctrl_en_ff & irq_sync[0];
      irq_ff.lapic_irq1       <= ctrl_en_ff & irq_sync[1];
      irq_ff.maskable_irq_req <= ~ctrl_en_ff & irq_sync[0];
      irq_ff.nmi_req          <= ~ctrl_en_ff & irq_sync[1];
    end
  end
  assign irq_out = irq_ff;

  // [R4] lock sequence tracking
  always_comb begin
    nxt_lock = lock_ff;
    case (lock_ff)
      sideband_pkg::lk_idle:
        if (lock_seq_start) nxt_lock = sideband_pkg::lk_locked;
      sideband_pkg::lk_locked:
        if (lock_seq_last_done) nxt_lock = sideband_pkg::lk_finish;
      sideband_pkg::lk_finish:
        nxt_lock = sideband_pkg::lk_idle;
      default:
        nxt_lock = sideband_pkg::lk_idle;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) lock_ff <= sideband_pkg::lk_idle;
    else     lock_ff <= nxt_lock;
  end

  // lock released one cycle after last completion, never mid-sequence
  always_ff @(posedge clk) begin
    if (rst) lock_ff_out <= 1'b0;
    else     lock_ff_out <= (nxt_lock == sideband_pkg::lk_locked);
  end
  assign bus_lock_n = ~lock_ff_out;

  // [R6] keep ownership while locked
  // [R5] priority agent yields to lock
  // same next-state term as the lock output, so ownership is already held
  // in the first cycle that bus-lock shows asserted
  always_ff @(posedge clk) begin
    if (rst) begin
      owner_ff <= 1'b1;
    end else if (nxt_lock == sideband_pkg::lk_locked) begin
      owner_ff <= 1'b1;
    end else begin
      owner_ff <= priority_bus_req_n;
    end
  end
  assign bus_owner = owner_ff;

  // [R7] overtemperature indication
  always_ff @(posedge clk) begin
    if (rst) begin
      hot_ff <= 1'b0;
      tca_ff <= 1'b0;
    end else begin
      hot_ff <= temp_max_detect;
      tca_ff <= temp_max_detect & thermal_ctrl_en;
    end
  end
  assign overtemp_n          = ~hot_ff;
  assign thermal_ctrl_active = tca_ff;

  // [R8] probe request to ready
  always_ff @(posedge clk) begin
    if (rst) begin
      probe_request_n_ff      <= 1'b0;
      probe_cnt_ff <= '0;
      probe_ready_n_ff      <= 1'b0;
    end else begin
      probe_request_n_ff <= ~probe_request_n;
      if (!probe_request_n_ff) begin
        probe_cnt_ff <= '0;
        probe_ready_n_ff      <= 1'b0;
      end else if (probe_cnt_ff != sideband_pkg::probe_ack_cycles) begin
        probe_cnt_ff <= probe_cnt_ff + 4'h1;
      end else begin
        probe_ready_n_ff <= debug_ready;
      end
    end
  end
  assign probe_ready_n = ~probe_ready_n_ff;

endmodule : cpu_sideband_lock_irq_logic
`default_nettype wire

// file: hdl/sideband_pkg.sv
// Operation
// [R1] With the local interrupt controller off, pin zero is a maskable request and pin one a nonmaskable interrupt.
// [R2] Both local interrupt pins are accepted as asynchronous inputs whatever their current role.
// [R3] After reset the local interrupt controller is on, and only a software configuration input moves the pins to their legacy roles.
// [R4] The bus-lock output stays asserted from the start of the first locked transaction to the end of the last.
// [R5] A priority agent holding its bus request waits for bus-lock to be seen deasserted before taking the bus.
// [R6] While bus-lock is asserted the device keeps bus ownership for the whole locked operation.
// [R7] The overtemperature output asserts when the monitor reports the maximum safe temperature, also marking thermal control activation when enabled.
// [R8] The debug tool asserts probe request, and the device drives probe ready once it is ready for debug.
// [R9] Each local interrupt input passes through a two-stage synchroniser on the bus clock before use.
package sideband_pkg;

  localparam logic [1:0] sync_reset_val = 2'h0;
  localparam logic       ctrl_en_reset  = 1'h1;
  // cycles counted after a taken probe request; probe ready follows one cycle later
  localparam logic [3:0] probe_ack_cycles = 4'h4;

  typedef enum logic [2:0] {
    lk_idle   = 3'b001,
    lk_locked = 3'b010,
    lk_finish = 3'b100
  } lock_state_t;

  typedef struct packed {
    logic lapic_irq0;
    logic lapic_irq1;
    logic maskable_irq_req;
    logic nmi_req;
  } irq_out_t;

endpackage : sideband_pkg

// file: hdl/sync2.sv
`timescale 1ns/1ps
`default_nettype none
module sync2 (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);
  logic meta_ff;
  logic q_ff;

  // [R9] two flop sync
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= 1'b0;
      q_ff    <= 1'b0;
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule : sync2
`default_nettype wire
